// ==== hdl/adcp_sample_port.sv ====
// Digital side of a 12-bit pipelined sampling converter.
// Assumes the conversion clock, the two input codes and the straps come
// from outside the 20 MHz domain; all are synchronised before use.
// Behaviour
// - Each rising conversion-clock edge seen while idle starts one new conversion.
// - Positive and negative inputs are captured together as a difference.
// - Result shows after two more start edges plus two 50 ns cycles (70 ns rounded up).
// - After 500 us without an edge an internal timer refreshes logic.
// - Result is a 12-bit two's complement word, bit 11 most significant.
// - Out-of-range flag is high exactly at either full-scale code.
// - Gain strap high gives gain 1, low gives gain 2.
// - Reference strap picks 4.096 V, 2.048 V or an external reference.
// - A started conversion cannot be stopped or restarted until done.
// - Only rising conversion-clock edges time the block.
`timescale 1ns/1ps

module adcp_sample_port #(
  parameter int IDLE_LIMIT = adcp_pkg::IDLE_CYCLES
) (
  input wire logic i_clock, // System clock, 20 MHz.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire logic i_conv_clock, // Conversion clock pin from the host.
  input wire logic [11:0] i_input_pos, // Positive input, as a code.
  input wire logic [11:0] i_input_neg, // Negative input, as a code.
  input wire logic i_gain_select, // Gain strap, high for gain 1.
  input wire logic [1:0] i_ref_select, // Reference strap.
  output logic [11:0] o_sample_code_bus, // Result word.
  output logic o_out_of_range_flag, // High at a full-scale code.
  output logic o_ref_amp_on, // Internal reference amplifier drives.
  output logic o_ref_half, // Internal reference is 2.048 V.
  output logic o_refresh // One-cycle refresh of dynamic logic.
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] clk_sync;
  logic [11:0] pos_meta, pos_sync, neg_meta, neg_sync;
  adcp_pkg::adcp_strap_t strap_meta, strap_sync;
  logic clk_prev;

  // Two flip-flops on the conversion clock, both input codes and the straps; the first stage feeds only the second.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clk_sync <= 2'h0;
      pos_meta <= 12'h000;
      pos_sync <= 12'h000;
      neg_meta <= 12'h000;
      neg_sync <= 12'h000;
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], i_conv_clock};
      pos_meta <= i_input_pos;
      pos_sync <= pos_meta;
      neg_meta <= i_input_neg;
      neg_sync <= neg_meta;
      strap_meta <= {i_gain_select, i_ref_select};
      strap_sync <= strap_meta;
      clk_prev <= clk_sync[1];
    end
  end

  // A start is a rising edge only; falling edges do nothing.
  logic start_edge;
  assign start_edge = clk_sync[1] & ~clk_prev;

  // ----------------------------------------------------------------------
  // Sample front end
  // ----------------------------------------------------------------------
  logic signed [14:0] diff;
  logic signed [14:0] scaled;
  logic [11:0] new_code;

  // Difference of both inputs, scaled by gain and reference, saturated.
  always_comb
  begin
    diff = 15'(signed'({{3{pos_sync[11]}}, pos_sync}))
         - 15'(signed'({{3{neg_sync[11]}}, neg_sync}));
    scaled = diff;
    if (!strap_sync.gain_one)
      scaled = scaled <<< 1;
    if (strap_sync.ref_select == adcp_pkg::REF_TIED_REF)
      scaled = scaled <<< 1;
    if (scaled > 15'sh07FF)
      new_code = adcp_pkg::CODE_POS_FULL;
    else if (scaled < -15'sh0800)
      new_code = adcp_pkg::CODE_NEG_FULL;
    else
      new_code = scaled[11:0];
  end

  // ----------------------------------------------------------------------
  // Conversion pipeline and output
  // ----------------------------------------------------------------------
  adcp_pkg::adcp_state_t state, next_state;
  logic [1:0] conv_cnt, next_conv_cnt;
  logic [11:0] pipe [adcp_pkg::PIPE_DEPTH];
  logic [11:0] next_pipe [adcp_pkg::PIPE_DEPTH];
  adcp_pkg::adcp_result_t result, next_result;
  logic take;

  // An edge is taken only while no conversion is running.
  assign take = start_edge && state == adcp_pkg::ST_IDLE;

  // Shift the three stages on each taken edge; update output at the end.
  always_comb
  begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_result = result;
    next_pipe[0] = pipe[0];
    for (int i = 1; i < adcp_pkg::PIPE_DEPTH; i++)
      next_pipe[i] = pipe[i];
    unique case (state)
      adcp_pkg::ST_IDLE:
      begin
        if (take)
        begin
          next_pipe[0] = new_code;
          for (int i = 1; i < adcp_pkg::PIPE_DEPTH; i++)
            next_pipe[i] = pipe[i - 1];
          next_conv_cnt = 2'(adcp_pkg::CONV_CYCLES - 1);
          next_state = adcp_pkg::ST_BUSY;
        end
      end
      adcp_pkg::ST_BUSY:
      begin
        if (conv_cnt == 2'h0)
        begin
          next_result.code = pipe[adcp_pkg::PIPE_DEPTH - 1];
          next_result.out_of_range =
            pipe[adcp_pkg::PIPE_DEPTH - 1] == adcp_pkg::CODE_POS_FULL ||
            pipe[adcp_pkg::PIPE_DEPTH - 1] == adcp_pkg::CODE_NEG_FULL;
          next_state = adcp_pkg::ST_IDLE;
        end
        else
          next_conv_cnt = conv_cnt - 2'h1;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= adcp_pkg::ST_IDLE;
      conv_cnt <= 2'h0;
      result <= {adcp_pkg::CODE_RESET, 1'b0};
      for (int i = 0; i < adcp_pkg::PIPE_DEPTH; i++)
        pipe[i] <= 12'h000;
    end
    else
    begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      result <= next_result;
      for (int i = 0; i < adcp_pkg::PIPE_DEPTH; i++)
        pipe[i] <= next_pipe[i];
    end
  end

  // Code and flag come from one register, so they change together.
  assign o_sample_code_bus = result.code;
  assign o_out_of_range_flag = result.out_of_range;

  // ----------------------------------------------------------------------
  // Idle refresh timer and reference status
  // ----------------------------------------------------------------------
  logic [15:0] idle_cnt, next_idle_cnt;
  logic next_refresh, next_amp_on, next_half;

  // Counts cycles since the last start edge and pulses a refresh.
  always_comb
  begin
    next_idle_cnt = idle_cnt + 16'h0001;
    next_refresh = 1'b0;
    if (start_edge)
      next_idle_cnt = 16'h0000;
    else if (idle_cnt == 16'(IDLE_LIMIT - 1))
    begin
      next_idle_cnt = 16'h0000;
      next_refresh = 1'b1;
    end
    next_amp_on = strap_sync.ref_select[1] == 1'b0;
    next_half = strap_sync.ref_select == adcp_pkg::REF_TIED_REF;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      idle_cnt <= 16'h0000;
      o_refresh <= 1'b0;
      o_ref_amp_on <= 1'b1;
      o_ref_half <= 1'b0;
    end
    else
    begin
      idle_cnt <= next_idle_cnt;
      o_refresh <= next_refresh;
      o_ref_amp_on <= next_amp_on;
      o_ref_half <= next_half;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_start_taken: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    start_edge && state == adcp_pkg::ST_IDLE |=>
      state == adcp_pkg::ST_BUSY)
    else $error("Start edge did not begin a conversion.");

  a_capture_diff: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    take |=> pipe[0] == $past(new_code))
    else $error("Sample not captured at the start edge.");

  a_result_latency: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    take |=> ##1 state == adcp_pkg::ST_BUSY ##1
      (result.code == $past(pipe[2], 1) && state == adcp_pkg::ST_IDLE))
    else $error("Result not updated two cycles after start.");

  a_flag_match: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_out_of_range_flag == (o_sample_code_bus == 12'h7FF ||
      o_sample_code_bus == 12'h800))
    else $error("Out-of-range flag disagrees with code.");

  a_busy_ignores: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    state == adcp_pkg::ST_BUSY |=> $stable(pipe[0]))
    else $error("Pipeline moved during a conversion.");

  a_fall_ignored: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    $fell(clk_sync[1]) |=> $stable(pipe[0]))
    else $error("Falling edge treated as a start.");

  a_out_together: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    $changed(o_out_of_range_flag) |-> $past(state) == adcp_pkg::ST_BUSY)
    else $error("Flag changed outside a result update.");

  a_refresh_idle: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_refresh |-> $past(idle_cnt) == 16'(IDLE_LIMIT - 1) &&
      !$past(start_edge))
    else $error("Refresh without a full idle period.");

  a_gain_two: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !strap_sync.gain_one && strap_sync.ref_select == 2'h0 &&
      diff == 15'sh0001 |-> new_code == 12'h002)
    else $error("Gain two did not double the code.");

  a_ref_select: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    strap_sync.ref_select == 2'h2 |=> !o_ref_amp_on && !o_ref_half)
    else $error("External reference left amplifier on.");

endmodule // adcp_sample_port

// ==== hdl/adcp_pkg.sv ====
// Package for the pipelined converter sample port.
// Assumes a single 20 MHz system clock drives every user of these constants.
package adcp_pkg;

  // ----------------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam logic [11:0] CODE_POS_FULL = 12'h7FF;
  localparam logic [11:0] CODE_NEG_FULL = 12'h800;
  localparam logic [11:0] CODE_RESET = 12'h000;

  // Strap codes of the reference-select input.
  localparam logic [1:0] REF_TIED_LOW = 2'h0;
  localparam logic [1:0] REF_TIED_REF = 2'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 70;
  localparam int IDLE_TIME_US = 500;
  // Least time, rounded up to whole cycles.
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYCLES = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PIPE_DEPTH = 3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] code;
    logic out_of_range;
  } adcp_result_t;

  typedef struct packed {
    logic gain_one;
    logic [1:0] ref_select;
  } adcp_strap_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } adcp_state_t;

endpackage

// ==== test/adcp_host_model.sv ====
// Host model: makes the conversion clock and latches every result.
// Assumes the 20 MHz system clock; it acts 1 ns after each rising edge.
`timescale 1ns/1ps

module adcp_host_model (
  input wire logic i_clock, // System clock.
  input wire logic i_run, // Keep issuing conversion starts.
  input wire integer i_low, // Low phase in cycles.
  input wire integer i_high, // High phase in cycles.
  input wire adcp_pkg::adcp_result_t i_result, // Device result.
  output logic o_conv_clock, // Conversion clock pin.
  output logic o_cap_valid, // One-cycle capture strobe.
  output adcp_pkg::adcp_result_t o_cap // Latched result.
);
  // Each period is low then high; the clock stands low while idle.
  initial
  begin
    o_conv_clock = 1'b0;
    o_cap_valid = 1'b0;
    o_cap = '0;
    forever
    begin
      @(posedge i_clock);
      if (i_run)
      begin
        repeat (i_low - 1) @(posedge i_clock);
        #1;
        o_conv_clock = 1'b1;
        o_cap = i_result;
        o_cap_valid = 1'b1;
        @(posedge i_clock);
        #1;
        o_cap_valid = 1'b0;
        repeat (i_high - 1) @(posedge i_clock);
        #1;
        o_conv_clock = 1'b0;
      end
    end
  end
endmodule // adcp_host_model

// ==== test/test_adcp_sample_port.sv ====
// Self-checking bench for the converter sample port.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps

module test_adcp_sample_port;
  // --------
  // Signals
  // --------
  localparam int IDLE_LIM = 20;
  localparam int NSAMP = 10;
  localparam logic [11:0] EDGE [4] = '{12'h7FF, 12'h7FE, 12'h800, 12'h801};
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [11:0] i_input_pos = 12'h000;
  logic [11:0] i_input_neg = 12'h000;
  logic i_gain_select = 1'b1;
  logic [1:0] i_ref_select = 2'h0;
  logic [11:0] o_sample_code_bus;
  logic o_out_of_range_flag, o_ref_amp_on, o_ref_half, o_refresh;
  logic run = 1'b0;
  int low_cyc = 3;
  int high_cyc = 3;
  logic conv_clock, cap_valid;
  adcp_pkg::adcp_result_t result, cap;
  adcp_pkg::adcp_result_t exp_q[$];
  int err_total = 0;
  int n_tests = 0;

  // Clock and result carrier.
  always #25 i_clock = ~i_clock;
  assign result = {o_sample_code_bus, o_out_of_range_flag};

  adcp_sample_port #(.IDLE_LIMIT(IDLE_LIM)) DUT (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_conv_clock(conv_clock),
    .i_input_pos(i_input_pos), .i_input_neg(i_input_neg),
    .i_gain_select(i_gain_select), .i_ref_select(i_ref_select),
    .o_sample_code_bus(o_sample_code_bus),
    .o_out_of_range_flag(o_out_of_range_flag),
    .o_ref_amp_on(o_ref_amp_on), .o_ref_half(o_ref_half),
    .o_refresh(o_refresh));

  adcp_host_model u_host (
    .i_clock(i_clock), .i_run(run), .i_low(low_cyc), .i_high(high_cyc),
    .i_result(result), .o_conv_clock(conv_clock), .o_cap_valid(cap_valid),
    .o_cap(cap));

  // --------
  // Tasks
  // --------
  task automatic check(string what, logic [12:0] expv, logic [12:0] got);
    n_tests++;
    if (got !== expv)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Counts cycles until the refresh output is next seen high.
  task automatic wait_pulse(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge i_clock);
      #1;
      cyc++;
    end
    while (o_refresh !== 1'b1 && cyc < 200);
  endtask

  // Expected word: scaled, saturated difference of the two codes.
  function automatic adcp_pkg::adcp_result_t calc(logic [11:0] p,
                                                  logic [11:0] n);
    int d;
    adcp_pkg::adcp_result_t r;
    d = int'($signed(p)) - int'($signed(n));
    if (i_gain_select == 1'b0) d = d * 2;
    if (i_ref_select == adcp_pkg::REF_TIED_REF) d = d * 2;
    d = (d > 2047) ? 2047 : ((d < -2048) ? -2048 : d);
    r.code = d[11:0];
    r.out_of_range = (r.code == adcp_pkg::CODE_POS_FULL) ||
                     (r.code == adcp_pkg::CODE_NEG_FULL);
    return r;
  endfunction

  // Scoreboard: each capture is matched with the oldest expectation.
  always @(posedge i_clock)
  begin
    if (cap_valid)
    begin
      if (exp_q.size() > 0)
        check("result", exp_q.pop_front(), cap);
      else
      begin
        err_total++;
        $display("Error capture expected none seen %h", cap);
      end
    end
    if (run === 1'b1)
      check("refresh while clocked", 13'h0000, 13'(o_refresh));
  end

  // Watchdog that cuts a hang short.
  initial
  begin
    repeat (6000) @(posedge i_clock);
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end

  // --------
  // Sequence
  // --------
  initial
  begin : main
    logic [11:0] p;
    logic [11:0] n;
    logic half_exp;
    int t;
    void'($urandom(61946));
    repeat (9) @(posedge i_clock);
    for (int k = 0; k < 8; k++)
    begin
      if (k > 0)
        @(posedge i_clock);
      #1;
      i_reset_n = 1'b0;
      i_gain_select = k[2];
      i_ref_select = k[1:0];
      low_cyc = 3 + (k % 3) * 2;
      high_cyc = 3 + (k % 2) * 4;
      exp_q.delete();
      repeat (3) exp_q.push_back('0);
      @(posedge i_clock);
      #1;
      i_reset_n = 1'b1;
      run = 1'b1;
      for (int i = 0; i < NSAMP; i++)
      begin
        p = (i < 4) ? EDGE[i] : 12'($urandom());
        n = (i < 4) ? 12'h000 : 12'($urandom());
        i_input_pos = p;
        i_input_neg = n;
        exp_q.push_back(calc(p, n));
        @(posedge conv_clock);
        @(negedge conv_clock);
      end
      run = 1'b0;
      half_exp = i_ref_select == adcp_pkg::REF_TIED_REF;
      check("pending", 13'h0003, 13'(exp_q.size()));
      check("amp on", 13'(!i_ref_select[1]), 13'(o_ref_amp_on));
      check("half ref", 13'(half_exp), 13'(o_ref_half));
      wait_pulse(t);
      wait_pulse(t);
      check("refresh spacing", 13'(IDLE_LIM), 13'(t));
    end
    report_and_stop();
  end
endmodule // test_adcp_sample_port
